// File: src/wdg_pkg.sv
package wdg_pkg;

   // Timing
   localparam int          CLK_PERIOD_NS     = 50;
   localparam int          PRESCALE_CYCLES   = 16384;
   localparam int          RESET_PULSE_NS    = 500;
   localparam int          RESET_PULSE_CYC   = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          OPT_LOCK_CYC      = 3;

   // Register map (8-bit data)
   localparam logic [7:0]  ADDR_CTRL         = 8'h2a;
   localparam logic [7:0]  ADDR_TBSEL        = 8'h2b;
   localparam logic [7:0]  ADDR_TMIN0        = 8'h2c;
   localparam logic [7:0]  ADDR_TMIN1        = 8'h2d;
   localparam logic [7:0]  ADDR_TMIN2        = 8'h2e;
   localparam logic [7:0]  ADDR_TMAX0        = 8'h2f;
   localparam logic [7:0]  ADDR_TMAX1        = 8'h30;
   localparam logic [7:0]  ADDR_TMAX2        = 8'h31;
   localparam logic [7:0]  ADDR_STATUS       = 8'h32;

   // Control register fields
   localparam int          CTRL_ARM_BIT      = 7;
   localparam int          CTRL_EXPIRY_BIT   = 6;
   localparam logic [7:0]  CTRL_RESET        = 8'h7f;
   localparam logic [6:0]  CNT_ROLL_FROM     = 7'h40;
   localparam logic [1:0]  TBSEL_RESET       = 2'h0;

   // Status register fields
   localparam int          STAT_ARMED_BIT    = 0;
   localparam int          STAT_HWWDG_BIT    = 1;
   localparam int          STAT_STOPRST_BIT  = 2;

   // Timeout correction pairs per timebase
   localparam logic [7:0]  TB0_MSB           = 8'h04;
   localparam logic [7:0]  TB0_LSB           = 8'h3b;
   localparam logic [7:0]  TB1_MSB           = 8'h08;
   localparam logic [7:0]  TB1_LSB           = 8'h35;
   localparam logic [7:0]  TB2_MSB           = 8'h14;
   localparam logic [7:0]  TB2_LSB           = 8'h23;
   localparam logic [7:0]  TB3_MSB           = 8'h31;
   localparam logic [7:0]  TB3_LSB           = 8'h36;
   localparam logic [23:0] TMIN0_OFFS        = 24'h000080;
   localparam logic [23:0] CORR_OFFS         = 24'h0000c0;
   localparam logic [23:0] CORR_STEP         = 24'h000040;
   localparam logic [23:0] TICK_CYCLES       = 24'h004000;

   typedef enum logic [0:0] {
      PULSE_IDLE,
      PULSE_LOW
   } wdg_pulse_state_t;

endpackage

// File: src/wdg_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module wdg_prescaler
   import wdg_pkg::*;
#(
   parameter int DIV = PRESCALE_CYCLES
)
(
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   // Tick out
   output logic      tick_o
);

   localparam int          CW      = $clog2(DIV);
   localparam logic [CW-1:0] LAST  = CW'(DIV - 1);

   logic [CW-1:0] cnt_q;

   // Free running; nothing but reset restarts it
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         cnt_q <= '0;
      end
      else if (cnt_q == LAST)
      begin
         cnt_q <= '0;
      end
      else
      begin
         cnt_q <= cnt_q + CW'(1);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         tick_o <= 1'b0;
      end
      else
      begin
         tick_o <= (cnt_q == LAST);
      end
   end

endmodule
`default_nettype wire

// File: src/wdg_pulse.sv
`timescale 1ns/1ps
`default_nettype none
module wdg_pulse
   import wdg_pkg::*;
#(
   parameter int WIDTH = RESET_PULSE_CYC
)
(
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   // Trigger and pin
   input  wire logic trig_i,
   output logic      pin_o,
   output logic      pin_oe_n_o
);

   localparam int            CW   = $clog2(WIDTH + 1);
   localparam logic [CW-1:0] LAST = CW'(WIDTH - 1);

   wdg_pulse_state_t state_q;
   logic [CW-1:0]    cnt_q;

   // Triggers during a pulse are absorbed; the pulse never stretches
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         state_q    <= PULSE_IDLE;
         cnt_q      <= '0;
         pin_o      <= 1'b1;
         pin_oe_n_o <= 1'b1;
      end
      else
      begin
         case (state_q)
            PULSE_IDLE:
            begin
               if (trig_i)
               begin
                  state_q    <= PULSE_LOW;
                  cnt_q      <= '0;
                  pin_o      <= 1'b0;
                  pin_oe_n_o <= 1'b0;
               end
            end
            PULSE_LOW:
            begin
               if (cnt_q == LAST)
               begin
                  state_q    <= PULSE_IDLE;
                  pin_o      <= 1'b1;
                  pin_oe_n_o <= 1'b1;
               end
               else
               begin
                  cnt_q <= cnt_q + CW'(1);
               end
            end
            default:
            begin
               state_q <= PULSE_IDLE;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// File: src/wdg_top.sv
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module wdg_top
   import wdg_pkg::*;
#(
   parameter int PRESCALE_DIV = PRESCALE_CYCLES,
   parameter int PULSE_CYC    = RESET_PULSE_CYC
)
(
   // Clock and reset
   input  wire logic       MCLK_I,
   input  wire logic       RST_N_I,
   // Register port
   input  wire logic [7:0] ADDR_I,
   input  wire logic [7:0] WDATA_I,
   input  wire logic       WR_I,
   input  wire logic       RD_I,
   output logic [7:0]      RDATA_O,
   // CPU events
   input  wire logic       STOP_EXEC_I,
   // Option settings
   input  wire logic       HW_WDG_OPT_I,
   input  wire logic       STOP_RST_OPT_I,
   // Reset pin
   output logic            RESET_PIN_O,
   output logic            RESET_PIN_OE_N_O
);

   logic         tick;
   logic         pin_low;
   logic         pin_oe_n;
   logic         arm_q;
   logic         arm_d;
   logic [6:0]   cnt_q;
   logic [6:0]   cnt_d;
   logic [1:0]   tbsel_q;
   logic [1:0]   opt_meta_q;
   logic [1:0]   opt_sync_q;
   logic         hw_opt_q;
   logic         stop_opt_q;
   logic [1:0]   lock_cnt_q;
   logic         armed;
   logic         wr_ctrl;
   logic         roll_trig;
   logic         sw_trig;
   logic         stop_trig;
   logic         trig;
   logic         busy;
   logic [7:0]   msb;
   logic [7:0]   lsb;
   logic [7:0]   quo;
   logic [23:0]  tmin0;
   logic [23:0]  corr;
   logic [23:0]  tmin;
   logic [23:0]  tmax;
   logic [7:0]   rdata_d;

   wdg_prescaler #(
      .DIV        (PRESCALE_DIV)
   ) u_presc (
      .clk_i      (MCLK_I),
      .rst_n_i    (RST_N_I),
      .tick_o     (tick)
   );

   wdg_pulse #(
      .WIDTH      (PULSE_CYC)
   ) u_pulse (
      .clk_i      (MCLK_I),
      .rst_n_i    (RST_N_I),
      .trig_i     (trig),
      .pin_o      (pin_low),
      .pin_oe_n_o (pin_oe_n)
   );

   assign RESET_PIN_O      = pin_low;
   assign RESET_PIN_OE_N_O = pin_oe_n;
   assign busy             = ~pin_oe_n;

   // Option pins come from fuse logic outside this domain
   always_ff @(posedge MCLK_I)
   begin
      if (!RST_N_I)
      begin
         opt_meta_q <= 2'h0;
         opt_sync_q <= 2'h0;
      end
      else
      begin
         opt_meta_q <= {HW_WDG_OPT_I, STOP_RST_OPT_I};
         opt_sync_q <= opt_meta_q;
      end
   end

   // Captured shortly after release, then frozen until the next reset
   always_ff @(posedge MCLK_I)
   begin
      if (!RST_N_I)
      begin
         lock_cnt_q <= 2'h0;
         hw_opt_q   <= 1'b0;
         stop_opt_q <= 1'b0;
      end
      else if (lock_cnt_q != 2'(OPT_LOCK_CYC))
      begin
         lock_cnt_q <= lock_cnt_q + 2'h1;
         hw_opt_q   <= opt_sync_q[1];
         stop_opt_q <= opt_sync_q[0];
      end
   end

   assign armed   = arm_q | hw_opt_q;
   assign wr_ctrl = WR_I & (ADDR_I == ADDR_CTRL);

   // Control register next value
   always_comb
   begin
      arm_d = arm_q;
      cnt_d = cnt_q;
      if (wr_ctrl)
      begin
         arm_d = arm_q | WDATA_I[CTRL_ARM_BIT];
         cnt_d = WDATA_I[6:0];
      end
      else if (tick)
      begin
         cnt_d = cnt_q - 7'h01;
      end
   end

   // Holding the register at reset value during the pulse keeps it unarmed afterwards
   always_ff @(posedge MCLK_I)
   begin
      if (!RST_N_I || busy)
      begin
         arm_q <= CTRL_RESET[CTRL_ARM_BIT];
         cnt_q <= CTRL_RESET[6:0];
      end
      else
      begin
         arm_q <= arm_d;
         cnt_q <= cnt_d;
      end
   end

   always_ff @(posedge MCLK_I)
   begin
      if (!RST_N_I)
      begin
         tbsel_q <= TBSEL_RESET;
      end
      else if (WR_I && (ADDR_I == ADDR_TBSEL))
      begin
         tbsel_q <= WDATA_I[1:0];
      end
   end

   // Reset sources
   assign roll_trig = armed & tick & ~wr_ctrl & (cnt_q == CNT_ROLL_FROM);
   assign sw_trig   = wr_ctrl & (armed | WDATA_I[CTRL_ARM_BIT]) & ~WDATA_I[CTRL_EXPIRY_BIT];
   assign stop_trig = STOP_EXEC_I & armed & stop_opt_q;
   assign trig      = (roll_trig | sw_trig | stop_trig) & ~busy;

   // Timeout bounds in clock periods for the loaded count
   always_comb
   begin
      case (tbsel_q)
         2'h0:
         begin
            msb = TB0_MSB;
            lsb = TB0_LSB;
         end
         2'h1:
         begin
            msb = TB1_MSB;
            lsb = TB1_LSB;
         end
         2'h2:
         begin
            msb = TB2_MSB;
            lsb = TB2_LSB;
         end
         default:
         begin
            msb = TB3_MSB;
            lsb = TB3_LSB;
         end
      endcase
   end

   // Integer division truncates, as the bounds require
   assign quo   = {cnt_q[5:0], 2'b00} / msb;
   assign tmin0 = (TMIN0_OFFS + {16'h0, lsb}) * CORR_STEP;
   assign corr  = TICK_CYCLES * ({18'h0, cnt_q[5:0]} - {16'h0, quo})
                + (CORR_OFFS + {16'h0, lsb}) * CORR_STEP * {16'h0, quo};

   always_comb
   begin
      if ({2'b00, cnt_q[5:0]} < (msb >> 2))
      begin
         tmin = tmin0 + TICK_CYCLES * {18'h0, cnt_q[5:0]};
      end
      else
      begin
         tmin = tmin0 + corr;
      end
      if ({2'b00, cnt_q[5:0]} <= (msb >> 2))
      begin
         tmax = TICK_CYCLES + TICK_CYCLES * {18'h0, cnt_q[5:0]};
      end
      else
      begin
         tmax = TICK_CYCLES + corr;
      end
   end

   // Read decode; unmapped addresses read zero
   always_comb
   begin
      rdata_d = 8'h00;
      if (ADDR_I == ADDR_CTRL)
      begin
         rdata_d = {arm_q, cnt_q};
      end
      else if (ADDR_I == ADDR_TBSEL)
      begin
         rdata_d = {6'h00, tbsel_q};
      end
      else if (ADDR_I == ADDR_TMIN0)
      begin
         rdata_d = tmin[7:0];
      end
      else if (ADDR_I == ADDR_TMIN1)
      begin
         rdata_d = tmin[15:8];
      end
      else if (ADDR_I == ADDR_TMIN2)
      begin
         rdata_d = tmin[23:16];
      end
      else if (ADDR_I == ADDR_TMAX0)
      begin
         rdata_d = tmax[7:0];
      end
      else if (ADDR_I == ADDR_TMAX1)
      begin
         rdata_d = tmax[15:8];
      end
      else if (ADDR_I == ADDR_TMAX2)
      begin
         rdata_d = tmax[23:16];
      end
      else if (ADDR_I == ADDR_STATUS)
      begin
         rdata_d[STAT_ARMED_BIT]   = armed;
         rdata_d[STAT_HWWDG_BIT]   = hw_opt_q;
         rdata_d[STAT_STOPRST_BIT] = stop_opt_q;
      end
   end

   always_ff @(posedge MCLK_I)
   begin
      if (!RST_N_I)
      begin
         RDATA_O <= 8'h00;
      end
      else if (RD_I)
      begin
         RDATA_O <= rdata_d;
      end
      else
      begin
         RDATA_O <= 8'h00;
      end
   end

   // Checking helpers
   logic [15:0] since_tick_q;
   logic        tick_seen_q;

   always_ff @(posedge MCLK_I)
   begin
      if (!RST_N_I)
      begin
         since_tick_q <= 16'h0;
         tick_seen_q  <= 1'b0;
      end
      else if (tick)
      begin
         since_tick_q <= 16'h0;
         tick_seen_q  <= 1'b1;
      end
      else
      begin
         since_tick_q <= since_tick_q + 16'h1;
      end
   end

   // Counts the cycles the pin has been low, so the pulse length needs no long repetition
   logic [7:0]  low_cnt_q;

   always_ff @(posedge MCLK_I)
   begin
      if (!RST_N_I)
      begin
         low_cnt_q <= 8'h00;
      end
      else if (!RESET_PIN_O)
      begin
         low_cnt_q <= low_cnt_q + 8'h01;
      end
      else
      begin
         low_cnt_q <= 8'h00;
      end
   end

   default clocking cb @(posedge MCLK_I);
   endclocking
   default disable iff (!RST_N_I);

   tick_period_a: assert property (tick && tick_seen_q |-> since_tick_q == 16'(PRESCALE_DIV - 1))
      else $error("prescaler tick spacing wrong");

   decrement_a: assert property (tick && !wr_ctrl && !busy |=> cnt_q == $past(cnt_q) - 7'h01)
      else $error("counter did not decrement on tick");

   rollover_rst_a: assert property (roll_trig && !busy |=> !RESET_PIN_O && !RESET_PIN_OE_N_O)
      else $error("rollover while armed gave no reset");

   pulse_width_a: assert property ($rose(RESET_PIN_O) |-> low_cnt_q == 8'(PULSE_CYC))
      else $error("reset pulse width wrong");

   pulse_len_a: assert property (!RESET_PIN_O |-> low_cnt_q < 8'(PULSE_CYC))
      else $error("reset pulse too long");

   free_run_a: assert property (!armed && tick && cnt_q == CNT_ROLL_FROM && !WR_I && !STOP_EXEC_I && !busy
                                |=> RESET_PIN_O && cnt_q == 7'h3f)
      else $error("unarmed rollover misbehaved");

   arm_sticky_a: assert property (arm_q && !busy |=> arm_q || $past(busy))
      else $error("arm bit cleared without reset");

   sw_reset_a: assert property (wr_ctrl && WDATA_I[7:6] == 2'b10 && !busy |=> !RESET_PIN_O)
      else $error("software reset not issued");

   stop_rst_a: assert property (STOP_EXEC_I && armed && stop_opt_q && !busy |=> !RESET_PIN_O)
      else $error("stop while armed gave no reset");

   stop_opt_a: assert property (STOP_EXEC_I && !stop_opt_q && !WR_I && !tick && RESET_PIN_O |=> RESET_PIN_O)
      else $error("stop reset without option");

   ctrl_write_a: assert property (wr_ctrl && WDATA_I[6] && !busy
                                  |=> cnt_q == $past(WDATA_I[6:0]) && arm_q == ($past(arm_q) | $past(WDATA_I[7])))
      else $error("control write not stored");

   unarmed_after_a: assert property ($rose(RESET_PIN_O) |-> !arm_q && cnt_q == CTRL_RESET[6:0])
      else $error("watchdog armed after reset pulse");

   hw_mode_a: assert property (hw_opt_q && tick && cnt_q == CNT_ROLL_FROM && !wr_ctrl && !busy |=> !RESET_PIN_O)
      else $error("hardware watchdog did not fire");

   read_ctrl_a: assert property (RD_I && ADDR_I == ADDR_CTRL |=> RDATA_O == $past({arm_q, cnt_q}))
      else $error("control read data wrong");

   tmin_base_a: assert property (cnt_q[5:0] == 6'h00 && tbsel_q == 2'h0 |-> tmin == 24'h002ec0 && tmax == TICK_CYCLES)
      else $error("timeout bounds wrong at zero count");

   timeout_cov: cover property (roll_trig ##1 !RESET_PIN_O);
   sw_reset_cov: cover property (sw_trig ##1 !RESET_PIN_O);
   stop_reset_cov: cover property (stop_trig ##1 !RESET_PIN_O);
   refresh_cov: cover property (wr_ctrl && WDATA_I[7:6] == 2'b11 ##1 arm_q);

endmodule
`default_nettype wire

// File: tb/windowed_free_running_watchdog_test.sv
`timescale 1ns/1ps
`default_nettype none
module windowed_free_running_watchdog_test
   import wdg_pkg::*;
;

   // Short prescale keeps the run small; the rollover windows below are derived from it
   localparam int DIV = 64;
   localparam int PW  = 10;

   logic        mclk;
   logic        rst_n;
   logic        wr;
   logic        rd;
   logic        stop;
   logic        hw_opt;
   logic        stp_opt;
   logic [7:0]  addr;
   logic [7:0]  wdata;
   logic [7:0]  rdata;
   logic        pin;
   logic        pin_oe_n;
   int          err_total;
   int          tests_run;
   logic [31:0] seed;
   int          msbs [4] = '{4, 8, 20, 49};
   int          lsbs [4] = '{59, 53, 35, 54};

   wdg_top #(
      .PRESCALE_DIV (DIV),
      .PULSE_CYC    (PW)
   ) wdg_top_inst (
      .MCLK_I           (mclk),
      .RST_N_I          (rst_n),
      .ADDR_I           (addr),
      .WDATA_I          (wdata),
      .WR_I             (wr),
      .RD_I             (rd),
      .RDATA_O          (rdata),
      .STOP_EXEC_I      (stop),
      .HW_WDG_OPT_I     (hw_opt),
      .STOP_RST_OPT_I   (stp_opt),
      .RESET_PIN_O      (pin),
      .RESET_PIN_OE_N_O (pin_oe_n)
   );

   initial
   begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Bound in clock cycles; integer division truncates
   function automatic int tbound(input int cnt, input int tb, input bit mx);
      int q;
      int base;
      q = (4 * cnt) / msbs[tb];
      base = mx ? 16384 : (lsbs[tb] + 128) * 64;
      if (mx ? (cnt <= msbs[tb] / 4) : (cnt < msbs[tb] / 4))
         return base + 16384 * cnt;
      return base + 16384 * (cnt - q) + (192 + lsbs[tb]) * 64 * q;
   endfunction

   task automatic give_verdict;
      $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge mclk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      rd <= 1'b1;
      addr <= a;
      @(posedge mclk);
      rd <= 1'b0;
      @(negedge mclk);
      d = rdata;
   endtask

   task automatic rd24(input logic [7:0] a, output logic [23:0] v);
      logic [7:0] b0;
      logic [7:0] b1;
      logic [7:0] b2;
      rd_reg(a, b0);
      rd_reg(a + 8'h01, b1);
      rd_reg(a + 8'h02, b2);
      v = {b2, b1, b0};
   endtask

   task automatic pulse_stop;
      @(posedge mclk);
      stop <= 1'b1;
      @(posedge mclk);
      stop <= 1'b0;
   endtask

   // Start must fall inside [lo, hi) cycles; enable tracks the pin throughout
   task automatic see_pulse(input int lo, input int hi);
      int n;
      int w;
      n = 0;
      w = 0;
      @(negedge mclk);
      while (pin !== 1'b0 && n < hi)
      begin
         @(negedge mclk);
         n++;
      end
      chk(n >= lo && n < hi, 1);
      while (pin === 1'b0 && w < 40)
      begin
         chk(pin_oe_n, 0);
         @(negedge mclk);
         w++;
      end
      chk(w, PW);
      chk(pin_oe_n, 1);
   endtask

   task automatic no_pulse(input int n);
      repeat (n)
      begin
         @(negedge mclk);
         chk(pin, 1);
      end
   endtask

   // Options change only inside reset, as the block expects them static
   task automatic do_reset(input logic h, input logic s);
      @(posedge mclk);
      rst_n <= 1'b0;
      hw_opt <= h;
      stp_opt <= s;
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (6) @(posedge mclk);
   endtask

   initial
   begin
      repeat (40000) @(posedge mclk);
      err_total++;
      give_verdict();
   end

   initial
   begin
      logic [7:0]  d;
      logic [7:0]  c1;
      logic [7:0]  c2;
      logic [23:0] vmin;
      logic [23:0] vmax;
      int          k;
      int          j;
      int          cnt;
      int          tb;
      err_total = 0;
      tests_run = 0;
      seed = 32'h00000062;
      rst_n = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      stop = 1'b0;
      hw_opt = 1'b0;
      stp_opt = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      do_reset(1'b0, 1'b0);
      rd_reg(ADDR_CTRL, d);
      chk(d, CTRL_RESET);
      rd_reg(ADDR_TBSEL, d);
      chk(d, 0);
      rd_reg(ADDR_STATUS, d);
      chk(d, 0);
      rd_reg(8'h00, d);
      chk(d, 0);
      // Exactly three ticks between two reads spaced three periods apart
      rd_reg(ADDR_CTRL, c1);
      repeat (3 * DIV - 2) @(posedge mclk);
      rd_reg(ADDR_CTRL, c2);
      chk(c1 - c2, 3);
      // Arm, then try to disarm with a refresh-like value
      wr_reg(ADDR_CTRL, 8'hc9);
      wr_reg(ADDR_CTRL, 8'h45);
      rd_reg(ADDR_CTRL, d);
      chk(d[7], 1);
      see_pulse(5 * DIV - 4, 6 * DIV + 4);
      rd_reg(ADDR_CTRL, d);
      chk(d[7:6], 2'b01);
      // Clearing the expiry bit unarmed is only stored
      wr_reg(ADDR_CTRL, 8'h3f);
      no_pulse(8);
      rd_reg(ADDR_CTRL, d);
      chk(d[7:6], 2'b00);
      wr_reg(ADDR_CTRL, 8'h80);
      see_pulse(0, 4);
      wr_reg(ADDR_CTRL, 8'hff);
      pulse_stop();
      no_pulse(8);
      do_reset(1'b0, 1'b1);
      pulse_stop();
      no_pulse(8);
      rd_reg(ADDR_STATUS, d);
      chk(d, 8'h04);
      wr_reg(ADDR_CTRL, 8'hff);
      pulse_stop();
      see_pulse(0, 4);
      do_reset(1'b1, 1'b0);
      rd_reg(ADDR_STATUS, d);
      chk(d, 8'h03);
      wr_reg(ADDR_CTRL, 8'h3f);
      see_pulse(0, 4);
      // Arm bit left clear: the option alone must let the rollover fire
      wr_reg(ADDR_CTRL, 8'h40);
      see_pulse(0, DIV + 4);
      do_reset(1'b0, 1'b0);
      wr_reg(ADDR_TMIN0, 8'hff);
      for (k = 0; k < 16; k++)
      begin
         tb = k % 4;
         cnt = (k < 4) ? 0 : (k < 8) ? 63 : int'(xs() % 64);
         wr_reg(ADDR_TBSEL, tb[7:0]);
         wr_reg(ADDR_CTRL, 8'h40 | cnt[7:0]);
         rd_reg(ADDR_TBSEL, d);
         chk(d, tb);
         // A tick between the reads spoils the sample, so retry
         for (j = 0; j < 3; j++)
         begin
            rd_reg(ADDR_CTRL, c1);
            rd24(ADDR_TMIN0, vmin);
            rd24(ADDR_TMAX0, vmax);
            rd_reg(ADDR_CTRL, c2);
            if (c1 === c2)
               break;
         end
         chk(vmin, tbound(c1[5:0], tb, 1'b0));
         chk(vmax, tbound(c1[5:0], tb, 1'b1));
      end
      give_verdict();
   end

endmodule
`default_nettype wire
